// >>> core/imm_load_exec.sv
`timescale 1ns/1ps
module imm_load_exec (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic [23:0] instr,
  input  wire logic [14:0] pc,
  input  wire logic        mem_ack,
  input  wire logic [23:0] mem_rdata,
  output logic             mem_rd_r,
  output logic [14:0]      mem_addr_r,
  output logic             done_r,
  output logic [14:0]      next_pc_r,
  output logic             shift_req_r,
  output logic [23:0]      acc_r,
  output logic [23:0]      aux_r,
  output logic [14:0]      idx1_r,
  output logic [14:0]      idx2_r,
  output logic [14:0]      idx3_r
);
  exec_pkg::state_e state_r;
  exec_pkg::state_e state_nxt;
  logic [5:0]       ldop_r;
  logic [5:0]       ldop_nxt;
  logic [14:0]      pcl_r;
  logic [14:0]      pcl_nxt;
  logic [1:0]       csel_r;
  logic [1:0]       csel_nxt;
  logic             mem_rd_nxt;
  logic [14:0]      mem_addr_nxt;
  logic             done_nxt;
  logic [14:0]      next_pc_nxt;
  logic             shift_req_nxt;
  logic [23:0]      acc_nxt;
  logic [23:0]      aux_nxt;
  logic [14:0]      idx_cur [0:3];
  logic [14:0]      idx_nxt [0:3];
  logic [5:0]       op;
  logic [2:0]       sel;
  logic [1:0]       bd;
  logic [14:0]      y;
  logic             is_idx;
  logic             is_q;
  logic             sgn;
  logic             take;
  logic [23:0]      yext;
  logic [23:0]      reg_val;
  logic [14:0]      idx_val;
  logic [23:0]      cmp_l;
  logic [23:0]      cmp_r;
  logic             cmp_s;
  logic             cmp_eq;
  logic             cmp_ge;
  logic [23:0]      t24;
  logic [14:0]      cidx;
  logic [5:0]       chr;

  // index file view; slot zero always reads as zero
  assign idx_cur[0] = exec_pkg::ZERO_A;
  assign idx_cur[1] = idx1_r;
  assign idx_cur[2] = idx2_r;
  assign idx_cur[3] = idx3_r;

  // instruction field decode and operand forming
  always_comb begin
    op      = instr[exec_pkg::OP_LSB +: 6];
    sel     = instr[exec_pkg::B_LSB +: 3];
    bd      = instr[exec_pkg::B_LSB +: 2];
    y       = instr[exec_pkg::AW-1:0];
    take    = start && (state_r == exec_pkg::ST_IDLE);
    is_idx  = ~instr[exec_pkg::SEL_BIT];
    is_q    = (sel == exec_pkg::SEL_Q_S) || (sel == exec_pkg::SEL_Q_U);
    sgn     = (sel == exec_pkg::SEL_A_S) || (sel == exec_pkg::SEL_Q_S);
    yext    = sgn ? exec_pkg::sext15(y)
                  : exec_pkg::zext15(y);
    reg_val = is_q ? aux_r : acc_r;
    idx_val = idx_cur[bd];
  end

  // compare operands: index 15 bits signed, register low 15 bits unsigned, full word signed
  always_comb begin
    if (is_idx) begin
      cmp_l = exec_pkg::sext15(idx_val);
      cmp_r = exec_pkg::sext15(y);
      cmp_s = 1'h1;
    end else if (sgn) begin
      cmp_l = reg_val;
      cmp_r = yext;
      cmp_s = 1'h1;
    end else begin
      cmp_l = exec_pkg::zext15(reg_val[exec_pkg::AW-1:0]);
      cmp_r = yext;
      cmp_s = 1'h0;
    end
  end

  cmp_unit u_cmp (
    .lhs        (cmp_l),
    .rhs        (cmp_r),
    .signed_cmp (cmp_s),
    .eq         (cmp_eq),
    .ge         (cmp_ge)
  );

  // character picked from the returned word, character 0 highest
  always_comb begin
    unique case (csel_r)
      2'h0: chr = mem_rdata[23:18];
      2'h1: chr = mem_rdata[17:12];
      2'h2: chr = mem_rdata[11:6];
      2'h3: chr = mem_rdata[5:0];
    endcase
  end

  // next-state and datapath for the execution sequence
  always_comb begin
    state_nxt     = state_r;
    ldop_nxt      = ldop_r;
    pcl_nxt       = pcl_r;
    csel_nxt      = csel_r;
    mem_addr_nxt  = mem_addr_r;
    done_nxt      = 1'h0;
    shift_req_nxt = 1'h0;
    next_pc_nxt   = next_pc_r;
    acc_nxt       = acc_r;
    aux_nxt       = aux_r;
    idx_nxt       = idx_cur;
    t24           = exec_pkg::ZERO_W;
    cidx          = exec_pkg::ZERO_A;
    unique case (state_r)
      exec_pkg::ST_IDLE: begin
        if (start) begin
          // immediate ops finish here with no storage cycle
          done_nxt    = 1'h1;
          next_pc_nxt = pc + exec_pkg::PC_STEP;
          ldop_nxt    = op;
          pcl_nxt     = pc;
          case (op)
            exec_pkg::OP_SKIP_EQ: begin
              if (cmp_eq) begin
                next_pc_nxt = pc + exec_pkg::PC_SKIP;
              end
            end
            exec_pkg::OP_SKIP_GE: begin
              if (cmp_ge) begin
                next_pc_nxt = pc + exec_pkg::PC_SKIP;
              end
            end
            exec_pkg::OP_ENTER: begin
              if (is_idx) begin
                idx_nxt[bd] = y;
              end else if (is_q) begin
                aux_nxt = yext;
              end else begin
                acc_nxt = yext;
              end
            end
            exec_pkg::OP_CHAR_ADDR: begin
              acc_nxt = {7'h00, instr[exec_pkg::CW-1:0]};
            end
            exec_pkg::OP_INCR: begin
              if (is_idx) begin
                t24 = exec_pkg::ones_add(exec_pkg::sext15(idx_val),
                                         exec_pkg::sext15(y));
                idx_nxt[bd] = t24[exec_pkg::AW-1:0];
              end else if (is_q) begin
                aux_nxt = exec_pkg::ones_add(reg_val, yext);
              end else begin
                acc_nxt = exec_pkg::ones_add(reg_val, yext);
              end
            end
            exec_pkg::OP_XOR: begin
              if (is_idx) begin
                idx_nxt[bd] = idx_val ^ y;
              end else if (is_q) begin
                aux_nxt = reg_val ^ yext;
              end else begin
                acc_nxt = reg_val ^ yext;
              end
            end
            exec_pkg::OP_AND: begin
              if (is_idx) begin
                idx_nxt[bd] = idx_val & y;
              end else if (is_q) begin
                aux_nxt = reg_val & yext;
              end else begin
                acc_nxt = reg_val & yext;
              end
            end
            exec_pkg::OP_INDEX_SKIP: begin
              if (is_idx && (bd == 2'h0)) begin
                // handed to the sequencer as a storage shift
                done_nxt      = 1'h0;
                shift_req_nxt = 1'h1;
              end else if (idx_val == y) begin
                // designator zero reads as zero, so y of zero skips
                idx_nxt[bd] = exec_pkg::ZERO_A;
                next_pc_nxt = pc + exec_pkg::PC_SKIP;
              end else begin
                t24 = exec_pkg::ones_add(exec_pkg::sext15(idx_val),
                        is_idx ? exec_pkg::ONE_P : exec_pkg::ONE_N);
                idx_nxt[bd] = t24[exec_pkg::AW-1:0];
              end
            end
            exec_pkg::OP_LD_WORD, exec_pkg::OP_LD_CPL,
            exec_pkg::OP_LD_MASK, exec_pkg::OP_LD_DBL: begin
              done_nxt    = 1'h0;
              next_pc_nxt = next_pc_r;
              if (instr[exec_pkg::SEL_BIT]) begin
                mem_addr_nxt = y;
                state_nxt    = exec_pkg::ST_IND;
              end else begin
                t24 = exec_pkg::ones_add(exec_pkg::sext15(y),
                                         exec_pkg::sext15(idx_val));
                mem_addr_nxt = t24[exec_pkg::AW-1:0];
                state_nxt    = exec_pkg::ST_RD1;
              end
            end
            exec_pkg::OP_LD_ACHR, exec_pkg::OP_LD_QCHR: begin
              // no indirect bit here; bit 17 only enables adding the index
              done_nxt    = 1'h0;
              next_pc_nxt = next_pc_r;
              cidx = (op == exec_pkg::OP_LD_ACHR) ? idx_cur[1]
                                                  : idx_cur[2];
              t24 = exec_pkg::ones_add({7'h00, instr[exec_pkg::CW-1:0]},
                      instr[exec_pkg::SEL_BIT] ? exec_pkg::sext15(cidx)
                                               : exec_pkg::ZERO_W);
              mem_addr_nxt = t24[exec_pkg::CW-1:2];
              csel_nxt     = t24[1:0];
              state_nxt    = exec_pkg::ST_RD1;
            end
            default: begin
              // opcodes outside this group are ignored
              done_nxt    = 1'h0;
              next_pc_nxt = next_pc_r;
            end
          endcase
        end
      end
      exec_pkg::ST_IND: begin
        if (mem_ack) begin
          if (mem_rdata[exec_pkg::SEL_BIT]) begin
            mem_addr_nxt = mem_rdata[exec_pkg::AW-1:0];
          end else begin
            t24 = exec_pkg::ones_add(
                    exec_pkg::sext15(mem_rdata[exec_pkg::AW-1:0]),
                    exec_pkg::sext15(idx_cur[mem_rdata[16:15]]));
            mem_addr_nxt = t24[exec_pkg::AW-1:0];
            state_nxt    = exec_pkg::ST_RD1;
          end
        end
      end
      exec_pkg::ST_RD1: begin
        if (mem_ack) begin
          state_nxt   = exec_pkg::ST_IDLE;
          done_nxt    = 1'h1;
          next_pc_nxt = pcl_r + exec_pkg::PC_STEP;
          case (ldop_r)
            exec_pkg::OP_LD_CPL: acc_nxt = ~mem_rdata;
            exec_pkg::OP_LD_MASK: acc_nxt = aux_r & mem_rdata;
            exec_pkg::OP_LD_ACHR: acc_nxt = {18'h00000, chr};
            exec_pkg::OP_LD_QCHR: aux_nxt = {18'h00000, chr};
            exec_pkg::OP_LD_DBL: begin
              acc_nxt = mem_rdata;
              t24 = exec_pkg::ones_add(exec_pkg::sext15(mem_addr_r),
                                       exec_pkg::ONE_P);
              mem_addr_nxt = t24[exec_pkg::AW-1:0];
              state_nxt    = exec_pkg::ST_RD2;
              done_nxt     = 1'h0;
              next_pc_nxt  = next_pc_r;
            end
            default: acc_nxt = mem_rdata;
          endcase
        end
      end
      exec_pkg::ST_RD2: begin
        if (mem_ack) begin
          aux_nxt     = mem_rdata;
          state_nxt   = exec_pkg::ST_IDLE;
          done_nxt    = 1'h1;
          next_pc_nxt = pcl_r + exec_pkg::PC_STEP;
        end
      end
    endcase
    idx_nxt[0] = exec_pkg::ZERO_A;
    mem_rd_nxt = (state_nxt != exec_pkg::ST_IDLE);
  end

  // state and architectural registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= exec_pkg::ST_IDLE;
      ldop_r      <= 6'h00;
      pcl_r       <= exec_pkg::ZERO_A;
      csel_r      <= 2'h0;
      mem_rd_r    <= 1'h0;
      mem_addr_r  <= exec_pkg::ZERO_A;
      done_r      <= 1'h0;
      next_pc_r   <= exec_pkg::ZERO_A;
      shift_req_r <= 1'h0;
      acc_r       <= exec_pkg::ZERO_W;
      aux_r       <= exec_pkg::ZERO_W;
      idx1_r      <= exec_pkg::ZERO_A;
      idx2_r      <= exec_pkg::ZERO_A;
      idx3_r      <= exec_pkg::ZERO_A;
    end else begin
      state_r     <= state_nxt;
      ldop_r      <= ldop_nxt;
      pcl_r       <= pcl_nxt;
      csel_r      <= csel_nxt;
      mem_rd_r    <= mem_rd_nxt;
      mem_addr_r  <= mem_addr_nxt;
      done_r      <= done_nxt;
      next_pc_r   <= next_pc_nxt;
      shift_req_r <= shift_req_nxt;
      acc_r       <= acc_nxt;
      aux_r       <= aux_nxt;
      idx1_r      <= idx_nxt[1];
      idx2_r      <= idx_nxt[2];
      idx3_r      <= idx_nxt[3];
    end
  end

  // checks on decode results and load sequencing
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  property p_skip_low15;
    take && (op == exec_pkg::OP_SKIP_EQ) && (sel == exec_pkg::SEL_A_U)
      && (acc_r[14:0] == y) |=> done_r
      && (next_pc_r == 15'($past(pc) + exec_pkg::PC_SKIP));
  endproperty
  a_skip_low15: assert property (p_skip_low15)
    else $error("low-bit compare did not skip");

  property p_no_skip;
    take && (op == exec_pkg::OP_SKIP_GE) && !cmp_ge
      |=> next_pc_r == 15'($past(pc) + exec_pkg::PC_STEP);
  endproperty
  a_no_skip: assert property (p_no_skip)
    else $error("false compare did not continue at next word");

  property p_enter_signed;
    take && (op == exec_pkg::OP_ENTER) && (sel == exec_pkg::SEL_A_S)
      |=> acc_r == exec_pkg::sext15($past(y));
  endproperty
  a_enter_signed: assert property (p_enter_signed)
    else $error("signed enter not sign-extended");

  property p_neg_zero;
    take && (op == exec_pkg::OP_SKIP_GE) && (sel == exec_pkg::SEL_A_S)
      && (acc_r == exec_pkg::ZERO_W) && (y == exec_pkg::NEG_ZERO)
      |=> next_pc_r == 15'($past(pc) + exec_pkg::PC_SKIP);
  endproperty
  a_neg_zero: assert property (p_neg_zero)
    else $error("positive zero not above negative zero");

  property p_enter_idx0;
    take && (op == exec_pkg::OP_ENTER) && is_idx && (bd == 2'h0)
      |=> $stable(idx1_r) && $stable(idx2_r) && $stable(idx3_r)
      && $stable(acc_r) && $stable(aux_r);
  endproperty
  a_enter_idx0: assert property (p_enter_idx0)
    else $error("enter with designator zero changed a register");

  property p_xor_aux;
    take && (op == exec_pkg::OP_XOR) && (sel == exec_pkg::SEL_Q_U)
      |=> aux_r == ($past(aux_r) ^ exec_pkg::zext15($past(y)));
  endproperty
  a_xor_aux: assert property (p_xor_aux)
    else $error("exclusive OR into auxiliary wrong");

  property p_count_hit;
    take && (op == exec_pkg::OP_INDEX_SKIP) && is_idx && (bd == 2'h1)
      && (idx1_r == y) |=> (idx1_r == exec_pkg::ZERO_A)
      && (next_pc_r == 15'($past(pc) + exec_pkg::PC_SKIP));
  endproperty
  a_count_hit: assert property (p_count_hit)
    else $error("count skip match did not clear and skip");

  property p_shift_decode;
    take && (op == exec_pkg::OP_INDEX_SKIP) && is_idx && (bd == 2'h0)
      |=> shift_req_r && !done_r ##1 !shift_req_r;
  endproperty
  a_shift_decode: assert property (p_shift_decode)
    else $error("storage shift not decoded");

  property p_load_cpl;
    (state_r == exec_pkg::ST_RD1) && mem_ack
      && (ldop_r == exec_pkg::OP_LD_CPL)
      |=> done_r && (acc_r == ~$past(mem_rdata)) && !mem_rd_r;
  endproperty
  a_load_cpl: assert property (p_load_cpl)
    else $error("complement load wrong");

  property p_dbl_wrap;
    (state_r == exec_pkg::ST_RD1) && mem_ack
      && (ldop_r == exec_pkg::OP_LD_DBL)
      && (mem_addr_r == exec_pkg::NEG_ZERO)
      |=> mem_rd_r && (mem_addr_r == exec_pkg::ADDR_ONE) && !done_r;
  endproperty
  a_dbl_wrap: assert property (p_dbl_wrap)
    else $error("double load next address not one's complement");

  property p_imm_fast;
    take && (op == exec_pkg::OP_AND) |=> done_r && !mem_rd_r;
  endproperty
  a_imm_fast: assert property (p_imm_fast)
    else $error("immediate op used storage or was late");
endmodule // imm_load_exec

// >>> core/exec_pkg.sv
package exec_pkg;
  // operand, address and character widths
  localparam int W     = 24;
  localparam int AW    = 15;
  localparam int CW    = 17;
  localparam int CH    = 6;
  // instruction field positions
  localparam int OP_LSB  = 18;
  localparam int SEL_BIT = 17;
  localparam int B_LSB   = 15;

  // opcodes
  localparam logic [5:0] OP_SKIP_EQ    = 6'h04;
  localparam logic [5:0] OP_SKIP_GE    = 6'h05;
  localparam logic [5:0] OP_INDEX_SKIP = 6'h08;
  localparam logic [5:0] OP_CHAR_ADDR  = 6'h09;
  localparam logic [5:0] OP_ENTER      = 6'h0C;
  localparam logic [5:0] OP_INCR       = 6'h0D;
  localparam logic [5:0] OP_XOR        = 6'h0E;
  localparam logic [5:0] OP_AND        = 6'h0F;
  localparam logic [5:0] OP_LD_WORD    = 6'h10;
  localparam logic [5:0] OP_LD_ACHR    = 6'h12;
  localparam logic [5:0] OP_LD_QCHR    = 6'h13;
  localparam logic [5:0] OP_LD_CPL     = 6'h14;
  localparam logic [5:0] OP_LD_DBL     = 6'h15;
  localparam logic [5:0] OP_LD_MASK    = 6'h17;

  // register select codes in bits 17..15 (bit 17 low selects an index)
  localparam logic [2:0] SEL_A_U = 3'h4;
  localparam logic [2:0] SEL_Q_S = 3'h5;
  localparam logic [2:0] SEL_A_S = 3'h6;
  localparam logic [2:0] SEL_Q_U = 3'h7;

  // reset values and arithmetic constants
  localparam logic [23:0] ZERO_W   = 24'h000000;
  localparam logic [23:0] ONE_P    = 24'h000001;
  localparam logic [23:0] ONE_N    = 24'hFFFFFE;
  localparam logic [14:0] ZERO_A   = 15'h0000;
  localparam logic [14:0] NEG_ZERO = 15'h7FFF;
  localparam logic [14:0] ADDR_ONE = 15'h0001;
  localparam logic [14:0] PC_STEP  = 15'h0001;
  localparam logic [14:0] PC_SKIP  = 15'h0002;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IND  = 2'b01,
    ST_RD1  = 2'b11,
    ST_RD2  = 2'b10
  } state_e;

  // sign extension of a 15-bit quantity
  function automatic logic [23:0] sext15(input logic [14:0] v);
    return {{9{v[14]}}, v};
  endfunction

  // zero extension of a 15-bit quantity
  function automatic logic [23:0] zext15(input logic [14:0] v);
    return {9'h000, v};
  endfunction

  // one's complement add with end-around carry
  function automatic logic [23:0] ones_add(input logic [23:0] a,
                                           input logic [23:0] b);
    logic [24:0] s;
    s = {1'h0, a} + {1'h0, b};
    return s[23:0] + {23'h000000, s[24]};
  endfunction
endpackage

// >>> core/cmp_unit.sv
`timescale 1ns/1ps
// equal and greater-or-equal on two 24-bit words
module cmp_unit (
  input  wire logic [23:0] lhs,
  input  wire logic [23:0] rhs,
  input  wire logic        signed_cmp,
  output logic             eq,
  output logic             ge
);
  // one's complement order: sign first, then magnitude pattern
  always_comb begin
    eq = (lhs == rhs);
    if (signed_cmp && (lhs[23] != rhs[23])) begin
      ge = ~lhs[23];
    end else begin
      ge = (lhs >= rhs);
    end
  end
endmodule // cmp_unit

// >>> bench/mem_model.sv
`timescale 1ns/1ps
// storage model: answers one read at a time after lat wait cycles
module mem_model (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        mem_rd_r,
  input  wire logic [14:0] mem_addr_r,
  input  wire logic [3:0]  lat,
  output logic             mem_ack,
  output logic [23:0]      mem_rdata
);
  logic [3:0] wait_r;

  // released data lines invert every cycle while no word is returned
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 24'h000000;
    end else if (mem_rd_r && !mem_ack && wait_r >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= {~mem_addr_r[8:0], mem_addr_r ^ 15'h0100};
      wait_r <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r <= (mem_rd_r && !mem_ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule // mem_model

// >>> bench/test_immediate_and_load_exec.sv
`timescale 1ns/1ps
// bench for the immediate and load execution block
module test_immediate_and_load_exec;
  localparam logic [14:0] P = 15'h0100;
  logic        clock;
  logic        arst_n;
  logic        start;
  logic [23:0] instr;
  logic [3:0]  lat;
  logic [14:0] pc;
  logic        mem_ack;
  logic [23:0] mem_rdata;
  logic        mem_rd_r;
  logic [14:0] mem_addr_r;
  logic        done_r;
  logic [14:0] next_pc_r;
  logic        shift_req_r;
  logic [23:0] acc_r;
  logic [23:0] aux_r;
  logic [14:0] idx1_r;
  logic [14:0] idx2_r;
  logic [14:0] idx3_r;
  int          fail_count;
  int          check_count;

  imm_load_exec i_dut (.clock(clock), .arst_n(arst_n), .start(start),
    .instr(instr), .pc(pc), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .done_r(done_r),
    .next_pc_r(next_pc_r), .shift_req_r(shift_req_r), .acc_r(acc_r),
    .aux_r(aux_r), .idx1_r(idx1_r), .idx2_r(idx2_r), .idx3_r(idx3_r));

  mem_model i_mem (.clock(clock), .arst_n(arst_n), .mem_rd_r(mem_rd_r),
    .mem_addr_r(mem_addr_r), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  // expected storage word at an address
  function automatic logic [23:0] wd(input logic [14:0] a);
    return {~a[8:0], a ^ 15'h0100};
  endfunction

  function automatic logic [23:0] ix(input logic [14:0] v);
    return {9'h000, v};
  endfunction

  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, s, e);
    end
  endtask

  // issue one instruction and wait for its answer
  task automatic go(input logic [23:0] w);
    int n;
    @(posedge clock);
    start <= 1'b1;
    instr <= w;
    @(posedge clock);
    start <= 1'b0;
    #1;
    n = 0;
    while (done_r !== 1'b1 && shift_req_r !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 40) chk(24'h000000, 24'h000001);
  endtask

  // issue and compare the next address against a skip expectation
  task automatic sk(input logic [23:0] w, input logic s);
    go(w);
    chk(ix(next_pc_r), ix(s ? pc + 15'h0002 : pc + 15'h0001));
  endtask

  task automatic t_enter;
    go({6'h0C, 3'h4, 15'h7FFF});
    chk(acc_r, 24'h007FFF);
    chk(ix(next_pc_r), ix(P + 15'h0001));
    go({6'h0C, 3'h6, 15'h4000});
    chk(acc_r, 24'hFFC000);
    go({6'h0C, 3'h7, 15'h4001});
    chk(aux_r, 24'h004001);
    go({6'h0C, 3'h5, 15'h4001});
    chk(aux_r, 24'hFFC001);
    go({6'h0C, 3'h1, 15'h1234});
    chk(ix(idx1_r), 24'h001234);
    go({6'h0C, 3'h0, 15'h5555});
    chk(ix(idx1_r), 24'h001234);
    go({6'h09, 18'h1ABCD});
    chk(acc_r, 24'h01ABCD);
    $display("enter test end");
  endtask

  task automatic t_arith;
    go({6'h0C, 3'h4, 15'h0005});
    go({6'h0D, 3'h4, 15'h0003});
    chk(acc_r, 24'h000008);
    go({6'h0D, 3'h6, 15'h7FFE});
    chk(acc_r, 24'h000007);
    go({6'h0C, 3'h2, 15'h7FFE});
    go({6'h0D, 3'h2, 15'h0002});
    chk(ix(idx2_r), 24'h000001);
    go({6'h0E, 3'h4, 15'h7FFF});
    chk(acc_r, 24'h007FF8);
    go({6'h0E, 3'h6, 15'h4000});
    chk(acc_r, 24'hFFBFF8);
    go({6'h0F, 3'h7, 15'h00FF});
    chk(aux_r, 24'h000001);
    go({6'h0E, 3'h2, 15'h00F3});
    chk(ix(idx2_r), 24'h0000F2);
    go({6'h0F, 3'h2, 15'h0F0F});
    chk(ix(idx2_r), 24'h000002);
    $display("arith test end");
  endtask

  task automatic t_cmp;
    go({6'h09, 18'h1C005});
    sk({6'h04, 3'h4, 15'h4005}, 1'b1);
    sk({6'h04, 3'h6, 15'h4005}, 1'b0);
    sk({6'h05, 3'h4, 15'h4006}, 1'b0);
    sk({6'h05, 3'h6, 15'h4006}, 1'b1);
    go({6'h0C, 3'h4, 15'h0000});
    sk({6'h05, 3'h6, 15'h7FFF}, 1'b1);
    go({6'h0C, 3'h6, 15'h7FFF});
    sk({6'h05, 3'h6, 15'h0000}, 1'b0);
    go({6'h0C, 3'h7, 15'h0005});
    sk({6'h05, 3'h7, 15'h0006}, 1'b0);
    sk({6'h04, 3'h7, 15'h0005}, 1'b1);
    sk({6'h04, 3'h1, 15'h1234}, 1'b1);
    sk({6'h04, 3'h0, 15'h0000}, 1'b1);
    sk({6'h05, 3'h0, 15'h0001}, 1'b0);
    // next address wraps modulo the 15-bit address space
    @(posedge clock);
    pc <= 15'h7FFE;
    sk({6'h04, 3'h0, 15'h0000}, 1'b1);
    sk({6'h05, 3'h0, 15'h0001}, 1'b0);
    @(posedge clock);
    pc <= P;
    $display("compare test end");
  endtask

  task automatic t_iskip;
    go({6'h0C, 3'h2, 15'h0005});
    sk({6'h08, 3'h2, 15'h0007}, 1'b0);
    chk(ix(idx2_r), 24'h000006);
    go({6'h0C, 3'h2, 15'h0007});
    sk({6'h08, 3'h2, 15'h0007}, 1'b1);
    chk(ix(idx2_r), 24'h000000);
    go({6'h0C, 3'h3, 15'h0004});
    sk({6'h08, 3'h7, 15'h0002}, 1'b0);
    chk(ix(idx3_r), 24'h000003);
    go({6'h0C, 3'h3, 15'h0002});
    sk({6'h08, 3'h7, 15'h0002}, 1'b1);
    chk(ix(idx3_r), 24'h000000);
    sk({6'h08, 3'h4, 15'h0001}, 1'b0);
    sk({6'h08, 3'h4, 15'h0000}, 1'b1);
    go({6'h08, 3'h0, 15'h0003});
    chk({23'h000000, shift_req_r}, 24'h000001);
    chk({23'h000000, done_r}, 24'h000000);
    // an opcode outside the group gives no pulse and no storage read
    @(posedge clock);
    start <= 1'b1;
    instr <= {6'h30, 18'h00000};
    @(posedge clock);
    start <= 1'b0;
    #1;
    chk({21'h000000, done_r, mem_rd_r, shift_req_r}, 24'h000000);
    $display("index skip test end");
  endtask

  task automatic t_load;
    logic [23:0] v;
    v = wd(15'h0101);
    go({6'h10, 3'h0, 15'h0123});
    chk(acc_r, wd(15'h0123));
    chk(ix(next_pc_r), ix(P + 15'h0001));
    chk({23'h000000, mem_rd_r}, 24'h000000);
    chk(ix(mem_addr_r), ix(15'h0123));
    go({6'h0C, 3'h1, 15'h0005});
    go({6'h10, 3'h1, 15'h0123});
    chk(acc_r, wd(15'h0128));
    go({6'h10, 3'h4, 15'h0007});
    chk(acc_r, wd(15'h0107));
    go({6'h14, 3'h0, 15'h0123});
    chk(acc_r, ~wd(15'h0123));
    go({6'h0C, 3'h7, 15'h7F0F});
    go({6'h17, 3'h0, 15'h0123});
    chk(acc_r, 24'h007F0F & wd(15'h0123));
    @(posedge clock);
    lat <= 4'h3;
    go({6'h15, 3'h0, 15'h0200});
    chk(acc_r, wd(15'h0200));
    chk(aux_r, wd(15'h0201));
    go({6'h15, 3'h0, 15'h7FFF});
    chk(aux_r, wd(15'h0001));
    go({6'h12, 1'b0, 17'h00405});
    chk(acc_r, {18'h00000, v[17:12]});
    go({6'h0C, 3'h1, 15'h7FFE});
    go({6'h12, 1'b1, 17'h00405});
    chk(acc_r, {18'h00000, v[23:18]});
    go({6'h13, 1'b0, 17'h00406});
    chk(aux_r, {18'h00000, v[11:6]});
    $display("load test end");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // clock at 40 MHz
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // reset, then the scenarios in order
  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    instr = 24'h000000;
    lat = 4'h0;
    pc = P;
    fail_count = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    t_enter;
    t_arith;
    t_cmp;
    t_iskip;
    t_load;
    print_verdict;
  end

  // watchdog against a hung handshake
  initial begin
    #100000;
    fail_count++;
    print_verdict;
  end
endmodule // test_immediate_and_load_exec
